// file: design/tssc_timer_ctl.sv
// Purpose: Timers A, B and C with start/stop control behind a Wishbone slave.
// Assumes: Single clock; measure and capture inputs are synchronous.
// Notes:   Count sources divide the clock by 1, 2, 4 or 8.
`timescale 1ns/1ps
module tssc_timer_ctl (
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [tssc_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [tssc_pkg::DAT_W-1:0] wb_dat_i,
   output logic      [tssc_pkg::DAT_W-1:0] wb_dat_o,
   output logic                            wb_ack_o,
   input  wire logic                       measure_i,
   input  wire logic [1:0]                 capture_i,
   output logic                            timer_b_out_o,
   output logic                            irq_o
);
   import tssc_pkg::*;

   logic [2:0]       free_ff, nxt_free;
   logic [3:0]       src_ff, nxt_src;
   logic             tick_a, tick_b;
   logic             ack_ff, nxt_ack;
   logic [DAT_W-1:0] dat_ff, nxt_dat;
   logic             a_req_ff, nxt_a_req;
   logic [2:0]       a_msel_ff, nxt_a_msel;
   logic             a_edge_ff, nxt_a_edge;
   logic             a_undf_ff, nxt_a_undf;
   logic [7:0]       a_pre_rl_ff, nxt_a_pre_rl, a_pre_ff, nxt_a_pre;
   logic [7:0]       a_cnt_rl_ff, nxt_a_cnt_rl, a_cnt_ff, nxt_a_cnt;
   logic             a_meas_ff, nxt_a_meas;
   logic             a_seen_ff, nxt_a_seen;
   logic             b_req_ff, nxt_b_req;
   logic [1:0]       b_msel_ff, nxt_b_msel;
   logic             b_trig_ff, nxt_b_trig;
   logic [7:0]       b_pre_rl_ff, nxt_b_pre_rl, b_pre_ff, nxt_b_pre;
   logic [7:0]       b_prim_ff, nxt_b_prim, b_cnt_ff, nxt_b_cnt;
   logic             b_out_ff, nxt_b_out;
   logic             c_en_ff, nxt_c_en;
   logic [15:0]      c_cnt_ff, nxt_c_cnt;
   logic [15:0]      c_cap0_ff, nxt_c_cap0, c_cap1_ff, nxt_c_cap1;
   logic [7:0]       c_hi_ff, nxt_c_hi;
   logic [1:0]       cap_ff, nxt_cap;
   logic [IRQ_W-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
   logic             irq_ff, nxt_irq;
   logic             a_run, a_go, b_run, b_cnt_en;

   logic             req, wr, rd;
   logic [ADR_W-1:0] adr;
   logic [7:0]       wd0;
   logic             a_ppm, a_pre_unf, a_cnt_unf, a_rise;
   logic             b_os, b_go, b_pre_unf, b_cnt_unf, b_stop_os;
   logic             c_ovf;
   logic [1:0]       cap_rise;
   logic [IRQ_W-1:0] ev;
   logic [DAT_W-1:0] rdata;

   function automatic logic src_tick(input logic [1:0] sel, input logic [2:0] cnt);
      logic [2:0] msk;
      msk = 3'(({1'b0, 3'h1} << sel) - 4'h1);
      return (cnt & msk) == 3'h0;
   endfunction

   tssc_runctl u_run_a (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .req_i   (a_req_ff),
      .tick_i  (tick_a),
      .run_o   (a_run),
      .count_o (a_go)
   );

   tssc_runctl u_run_b (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .req_i   (b_req_ff),
      .tick_i  (tick_b),
      .run_o   (b_run),
      .count_o (b_cnt_en)
   );

   always_comb begin
      req       = wb_cyc_i & wb_stb_i & ~ack_ff;
      wr        = req & wb_we_i & wb_sel_i[0];
      rd        = req & ~wb_we_i;
      adr       = {wb_adr_i[ADR_W-1:2], 2'b00};
      wd0       = wb_dat_i[7:0];
      tick_a    = src_tick(src_ff[1:0], free_ff);
      tick_b    = src_tick(src_ff[SRC_B_LSB+1:SRC_B_LSB], free_ff);
      nxt_free  = free_ff + 3'h1;
      nxt_ack   = req;
      nxt_src   = src_ff;
      nxt_mask  = mask_ff;
      nxt_c_en  = c_en_ff;
      nxt_c_hi  = c_hi_ff;

      // Timer A: prescaler feeds counter, both reload at zero.
      a_ppm        = a_msel_ff == A_MODE_PPM;
      a_pre_unf    = a_go & (a_pre_ff == RST_BYTE);
      a_cnt_unf    = a_pre_unf & (a_cnt_ff == RST_BYTE);
      a_rise       = measure_i & ~a_meas_ff;
      nxt_a_meas   = measure_i;
      nxt_a_req    = a_req_ff;
      nxt_a_msel   = a_msel_ff;
      nxt_a_pre_rl = a_pre_rl_ff;
      nxt_a_cnt_rl = a_cnt_rl_ff;
      nxt_a_pre    = a_go ? (a_pre_unf ? a_pre_rl_ff : a_pre_ff - 8'h01) : a_pre_ff;
      nxt_a_cnt    = a_pre_unf ? (a_cnt_unf ? a_cnt_rl_ff : a_cnt_ff - 8'h01) : a_cnt_ff;
      // An edge is only reported at a prescaler underflow, so one seen just
      // before the start shows up at the first underflow after it.
      nxt_a_seen   = a_pre_unf ? a_rise : (a_seen_ff | a_rise);
      nxt_a_edge   = a_edge_ff;
      nxt_a_undf   = a_undf_ff;
      if (wr && adr == OFS_A_MODE) begin
         nxt_a_req  = wd0[A_RUN_BIT];
         nxt_a_msel = wd0[A_MSEL_LSB+2:A_MSEL_LSB];
         if (a_ppm) begin
            nxt_a_edge = a_edge_ff & wd0[A_EDGE_BIT];
            nxt_a_undf = a_undf_ff & wd0[A_UNDF_BIT];
         end else begin
            nxt_a_edge = wd0[A_EDGE_BIT];
            nxt_a_undf = wd0[A_UNDF_BIT];
         end
      end
      // Hardware setting beats a clear written in the same cycle.
      if (a_ppm && a_pre_unf && a_seen_ff) begin
         nxt_a_edge = 1'b1;
      end
      if (a_ppm && a_cnt_unf) begin
         nxt_a_undf = 1'b1;
      end
      if (wr && adr == OFS_A_PRESC) begin
         nxt_a_pre_rl = wd0;
         nxt_a_pre    = wd0;
      end
      if (wr && adr == OFS_A_COUNT) begin
         nxt_a_cnt_rl = wd0;
         nxt_a_cnt    = wd0;
      end

      // Timer B: one-shot modes count only while the trigger is set.
      b_os         = b_msel_ff[B_MSEL_OS_BIT];
      b_go         = b_cnt_en & (~b_os | b_trig_ff);
      b_pre_unf    = b_go & (b_pre_ff == RST_BYTE);
      b_cnt_unf    = b_pre_unf & (b_cnt_ff == RST_BYTE);
      nxt_b_req    = b_req_ff;
      nxt_b_msel   = b_msel_ff;
      nxt_b_trig   = b_trig_ff & ~(b_os & b_cnt_unf);
      nxt_b_pre_rl = b_pre_rl_ff;
      nxt_b_prim   = b_prim_ff;
      nxt_b_pre    = b_go ? (b_pre_unf ? b_pre_rl_ff : b_pre_ff - 8'h01) : b_pre_ff;
      nxt_b_cnt    = b_pre_unf ? (b_cnt_unf ? b_prim_ff : b_cnt_ff - 8'h01) : b_cnt_ff;
      b_stop_os    = 1'b0;
      if (wr && adr == OFS_B_MODE) begin
         nxt_b_req  = wd0[B_RUN_BIT];
         nxt_b_msel = wd0[B_MSEL_LSB+1:B_MSEL_LSB];
         nxt_b_trig = b_os & wd0[B_TRIG_BIT];
         b_stop_os  = b_os & (~wd0[B_RUN_BIT] | ~wd0[B_TRIG_BIT]);
      end
      if (wr && adr == OFS_B_PRESC) begin
         nxt_b_pre_rl = wd0;
         nxt_b_pre    = wd0;
      end
      if (wr && adr == OFS_B_PRIMARY) begin
         nxt_b_prim = wd0;
      end
      // The count value is lost here; software must read it before stopping.
      if (b_stop_os) begin
         nxt_b_cnt = b_prim_ff;
         nxt_b_pre = b_pre_rl_ff;
      end
      if (b_os) begin
         nxt_b_out = nxt_b_trig & b_run;
      end else begin
         nxt_b_out = b_out_ff ^ b_cnt_unf;
      end

      // Timer C: free-running 16-bit counter with two capture inputs.
      c_ovf      = c_en_ff & (c_cnt_ff == HALF_MAX);
      nxt_c_cnt  = c_en_ff ? c_cnt_ff + 16'h0001 : c_cnt_ff;
      cap_rise   = capture_i & ~cap_ff;
      nxt_cap    = capture_i;
      nxt_c_cap0 = cap_rise[0] ? c_cnt_ff : c_cap0_ff;
      nxt_c_cap1 = cap_rise[1] ? c_cnt_ff : c_cap1_ff;
      if (wr && adr == OFS_C_CTRL) begin
         nxt_c_en = wd0[C_EN_BIT];
      end
      if (wr && adr == OFS_SRC_SEL) begin
         nxt_src = wd0[3:0];
      end

      // Interrupt status: sticky, write one to clear, new events win.
      ev        = '0;
      ev[IRQ_A] = a_cnt_unf;
      ev[IRQ_B] = b_cnt_unf;
      ev[IRQ_C] = c_ovf;
      nxt_stat  = stat_ff;
      if (wr && adr == OFS_IRQ_STAT) begin
         nxt_stat = stat_ff & ~wd0[IRQ_W-1:0];
      end
      nxt_stat = nxt_stat | ev;
      if (wr && adr == OFS_IRQ_MASK) begin
         nxt_mask = wd0[IRQ_W-1:0];
      end
      nxt_irq = |(nxt_stat & nxt_mask);

      // Read mux; unmapped offsets answer with zero.
      rdata = '0;
      case (adr)
         OFS_A_MODE: begin
            rdata[A_RUN_BIT]                   = a_run;
            rdata[A_MSEL_LSB+2:A_MSEL_LSB]     = a_msel_ff;
            rdata[A_EDGE_BIT]                  = a_edge_ff;
            rdata[A_UNDF_BIT]                  = a_undf_ff;
         end
         OFS_A_PRESC:   rdata[7:0] = a_pre_ff;
         OFS_A_COUNT:   rdata[7:0] = a_cnt_ff;
         OFS_SRC_SEL:   rdata[3:0] = src_ff;
         OFS_B_MODE: begin
            rdata[B_RUN_BIT]                   = b_run;
            rdata[B_MSEL_LSB+1:B_MSEL_LSB]     = b_msel_ff;
            rdata[B_TRIG_BIT]                  = b_trig_ff;
         end
         OFS_B_PRESC:   rdata[7:0] = b_pre_ff;
         OFS_B_PRIMARY: rdata[7:0] = b_prim_ff;
         OFS_B_COUNT:   rdata[7:0] = b_cnt_ff;
         OFS_C_COUNT: begin
            // A low-byte read latches the high byte, so a split read still
            // returns one count value.
            if (wb_sel_i[0]) begin
               rdata[15:0] = c_cnt_ff;
            end else begin
               rdata[15:0] = {c_hi_ff, RST_BYTE};
            end
         end
         OFS_C_CAP0:    rdata[15:0] = c_cap0_ff;
         OFS_C_CAP1:    rdata[15:0] = c_cap1_ff;
         OFS_C_CTRL:    rdata[C_EN_BIT] = c_en_ff;
         OFS_IRQ_STAT:  rdata[IRQ_W-1:0] = stat_ff;
         OFS_IRQ_MASK:  rdata[IRQ_W-1:0] = mask_ff;
         default:       rdata = '0;
      endcase
      if (rd && adr == OFS_C_COUNT && wb_sel_i[0]) begin
         nxt_c_hi = c_cnt_ff[15:8];
      end
      nxt_dat = rd ? rdata : dat_ff;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         free_ff     <= 3'h0;
         src_ff      <= 4'h0;
         ack_ff      <= 1'b0;
         dat_ff      <= '0;
         a_req_ff    <= 1'b0;
         a_msel_ff   <= 3'h0;
         a_edge_ff   <= 1'b0;
         a_undf_ff   <= 1'b0;
         a_pre_rl_ff <= RST_BYTE;
         a_pre_ff    <= RST_BYTE;
         a_cnt_rl_ff <= RST_BYTE;
         a_cnt_ff    <= RST_BYTE;
         a_meas_ff   <= 1'b0;
         a_seen_ff   <= 1'b0;
         b_req_ff    <= 1'b0;
         b_msel_ff   <= 2'h0;
         b_trig_ff   <= 1'b0;
         b_pre_rl_ff <= RST_BYTE;
         b_pre_ff    <= RST_BYTE;
         b_prim_ff   <= RST_BYTE;
         b_cnt_ff    <= RST_BYTE;
         b_out_ff    <= 1'b0;
         c_en_ff     <= 1'b0;
         c_cnt_ff    <= RST_HALF;
         c_cap0_ff   <= RST_HALF;
         c_cap1_ff   <= RST_HALF;
         c_hi_ff     <= RST_BYTE;
         cap_ff      <= 2'h0;
         stat_ff     <= '0;
         mask_ff     <= '0;
         irq_ff      <= 1'b0;
      end else begin
         free_ff     <= nxt_free;
         src_ff      <= nxt_src;
         ack_ff      <= nxt_ack;
         dat_ff      <= nxt_dat;
         a_req_ff    <= nxt_a_req;
         a_msel_ff   <= nxt_a_msel;
         a_edge_ff   <= nxt_a_edge;
         a_undf_ff   <= nxt_a_undf;
         a_pre_rl_ff <= nxt_a_pre_rl;
         a_pre_ff    <= nxt_a_pre;
         a_cnt_rl_ff <= nxt_a_cnt_rl;
         a_cnt_ff    <= nxt_a_cnt;
         a_meas_ff   <= nxt_a_meas;
         a_seen_ff   <= nxt_a_seen;
         b_req_ff    <= nxt_b_req;
         b_msel_ff   <= nxt_b_msel;
         b_trig_ff   <= nxt_b_trig;
         b_pre_rl_ff <= nxt_b_pre_rl;
         b_pre_ff    <= nxt_b_pre;
         b_prim_ff   <= nxt_b_prim;
         b_cnt_ff    <= nxt_b_cnt;
         b_out_ff    <= nxt_b_out;
         c_en_ff     <= nxt_c_en;
         c_cnt_ff    <= nxt_c_cnt;
         c_cap0_ff   <= nxt_c_cap0;
         c_cap1_ff   <= nxt_c_cap1;
         c_hi_ff     <= nxt_c_hi;
         cap_ff      <= nxt_cap;
         stat_ff     <= nxt_stat;
         mask_ff     <= nxt_mask;
         irq_ff      <= nxt_irq;
      end
   end

   assign wb_dat_o      = dat_ff;
   assign wb_ack_o      = ack_ff;
   assign timer_b_out_o = b_out_ff;
   assign irq_o         = irq_ff;
endmodule : tssc_timer_ctl

// file: design/tssc_pkg.sv
// Purpose: Constants for the timer start/stop control block.
// Assumes: Classic Wishbone slave, 32-bit data, one word per register.
// Notes:   Offsets are byte addresses; all registers sit in the low bits.
// Functional notes
// - Timers A and B stay stopped after reset until software starts them.
// - Prescaler and counter of timers A and B are separate byte registers.
// - In pulse period mode, edge and underflow flags clear on 0, keep on 1.
// - Timer A edge flag may set at first prescaler underflow after start.
// - Timer A run bit reads 0 until next source edge; counting starts at the source edge after that.
// - Timer A stop request halts at next source edge; run reads 1 until then.
// - Timer B start behaves as timer A start; software waits for readback.
// - Timer B stop halts at next source edge; run reads 1 until then.
// - In timer B one-shot modes, clearing run or trigger reloads and stops.
// - Timer C counter reads as one 16-bit unit from a single count value.
package tssc_pkg;
   localparam int          ADR_W          = 6;
   localparam int          DAT_W          = 32;
   localparam logic [5:0]  OFS_A_MODE     = 6'h00;
   localparam logic [5:0]  OFS_A_PRESC    = 6'h04;
   localparam logic [5:0]  OFS_A_COUNT    = 6'h08;
   localparam logic [5:0]  OFS_SRC_SEL    = 6'h0c;
   localparam logic [5:0]  OFS_B_MODE     = 6'h10;
   localparam logic [5:0]  OFS_B_PRESC    = 6'h14;
   localparam logic [5:0]  OFS_B_PRIMARY  = 6'h18;
   localparam logic [5:0]  OFS_B_COUNT    = 6'h1c;
   localparam logic [5:0]  OFS_C_COUNT    = 6'h20;
   localparam logic [5:0]  OFS_C_CAP0     = 6'h24;
   localparam logic [5:0]  OFS_C_CAP1     = 6'h28;
   localparam logic [5:0]  OFS_C_CTRL     = 6'h2c;
   localparam logic [5:0]  OFS_IRQ_STAT   = 6'h30;
   localparam logic [5:0]  OFS_IRQ_MASK   = 6'h34;
   localparam int          A_RUN_BIT      = 0;
   localparam int          A_MSEL_LSB     = 1;
   localparam int          A_EDGE_BIT     = 4;
   localparam int          A_UNDF_BIT     = 5;
   localparam int          B_RUN_BIT      = 0;
   localparam int          B_MSEL_LSB     = 1;
   localparam int          B_TRIG_BIT     = 3;
   localparam int          SRC_B_LSB      = 2;
   localparam int          C_EN_BIT       = 0;
   localparam logic [2:0]  A_MODE_PPM     = 3'h3;
   localparam int          B_MSEL_OS_BIT  = 1;
   localparam int          IRQ_A          = 0;
   localparam int          IRQ_B          = 1;
   localparam int          IRQ_C          = 2;
   localparam int          IRQ_W          = 3;
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [15:0] RST_HALF       = 16'h0000;
   localparam logic [15:0] HALF_MAX       = 16'hffff;
endpackage : tssc_pkg

// file: design/tssc_runctl.sv
// Purpose: Run request to running flag, applied on count-source edges.
// Assumes: tick_i is a one-cycle pulse marking a count-source edge.
// Notes:   The running flag is what software reads back as the run bit.
`timescale 1ns/1ps
module tssc_runctl (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic req_i,
   input  wire logic tick_i,
   output logic      run_o,
   output logic      count_o
);
   logic run_ff;
   logic nxt_run;

   // The flag only follows the request at a source edge, so a start reads
   // 0 and a stop reads 1 until that edge arrives.
   always_comb begin
      nxt_run = tick_i ? req_i : run_ff;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         run_ff <= 1'b0;
      end else begin
         run_ff <= nxt_run;
      end
   end

   assign run_o   = run_ff;
   // Counting needs the flag already set and the request still held, so it
   // starts at the edge after the start and no count happens at the halt.
   assign count_o = tick_i & run_ff & req_i;
endmodule : tssc_runctl

// file: sim/tssc_asserts.sv
// Purpose: Port-level assertions for the timer start/stop block.
// Assumes: Ack comes exactly one cycle after a taken request.
// Notes:   Run readback may lag the request by one source period only.
`timescale 1ns/1ps
module tssc_asserts (
   input wire logic                       clk_i,
   input wire logic                       rst_n_i,
   input wire logic                       wb_cyc_i,
   input wire logic                       wb_stb_i,
   input wire logic                       wb_we_i,
   input wire logic [tssc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0]                 wb_sel_i,
   input wire logic [tssc_pkg::DAT_W-1:0] wb_dat_i,
   input wire logic [tssc_pkg::DAT_W-1:0] wb_dat_o,
   input wire logic                       wb_ack_o,
   input wire logic                       measure_i,
   input wire logic [1:0]                 capture_i,
   input wire logic                       timer_b_out_o,
   input wire logic                       irq_o
);
   import tssc_pkg::*;
   logic       tk, wr, rq;
   logic [3:0] a;
   logic [3:0] rd_ff, nxt_rd, a_age_ff, nxt_a_age, b_age_ff, nxt_b_age;
   logic       byte_ff, nxt_byte, a_req_ff, nxt_a_req, b_req_ff, nxt_b_req;
   logic [7:0] c_hi_ff, nxt_c_hi;
   assign a  = wb_adr_i[5:2];
   assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign rq = tk & ~wb_we_i;
   assign wr = tk & wb_we_i & wb_sel_i[0];
   // Ages saturate so an idle timer never wraps back into the grace window.
   always_comb begin
      nxt_rd[0] = rq & (a == OFS_A_MODE[5:2]);
      nxt_rd[1] = rq & (a == OFS_B_MODE[5:2]);
      nxt_rd[2] = rq & (a == OFS_C_COUNT[5:2]) & wb_sel_i[0];
      nxt_rd[3] = rq & (a == OFS_C_COUNT[5:2]) & ~wb_sel_i[0];
      nxt_byte  = rq & (a == OFS_A_PRESC[5:2] || a == OFS_A_COUNT[5:2] || a == OFS_B_PRESC[5:2]);
      nxt_a_req = (wr && a == OFS_A_MODE[5:2]) ? wb_dat_i[A_RUN_BIT] : a_req_ff;
      nxt_b_req = (wr && a == OFS_B_MODE[5:2]) ? wb_dat_i[B_RUN_BIT] : b_req_ff;
      nxt_a_age = (wr && a == OFS_A_MODE[5:2]) ? 4'h0 : a_age_ff + {3'h0, a_age_ff != 4'hf};
      nxt_b_age = (wr && a == OFS_B_MODE[5:2]) ? 4'h0 : b_age_ff + {3'h0, b_age_ff != 4'hf};
      nxt_c_hi  = (rd_ff[2] && wb_ack_o) ? wb_dat_o[15:8] : c_hi_ff;
   end
   always_ff @(posedge clk_i) begin
      rd_ff    <= rst_n_i ? nxt_rd : 4'h0;
      byte_ff  <= rst_n_i & nxt_byte;
      a_req_ff <= rst_n_i & nxt_a_req;
      b_req_ff <= rst_n_i & nxt_b_req;
      a_age_ff <= rst_n_i ? nxt_a_age : 4'h0;
      b_age_ff <= rst_n_i ? nxt_b_age : 4'h0;
      c_hi_ff  <= rst_n_i ? nxt_c_hi : 8'h00;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_ack_after_req; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_after_req: assert property (p_ack_after_req) else $error("ack missing after request");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_rst_quiet; $rose(rst_n_i) |-> !irq_o && !timer_b_out_o && !wb_ack_o; endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
   property p_a_run; rd_ff[0] && wb_ack_o && wb_dat_o[A_RUN_BIT] != a_req_ff |-> a_age_ff < 4'hc; endproperty
   a_a_run: assert property (p_a_run) else $error("timer a run readback lags");
   property p_b_run; rd_ff[1] && wb_ack_o && wb_dat_o[B_RUN_BIT] != b_req_ff |-> b_age_ff < 4'hc; endproperty
   a_b_run: assert property (p_b_run) else $error("timer b run readback lags");
   property p_c_pair; rd_ff[3] && wb_ack_o |-> wb_dat_o[15:0] == {c_hi_ff, 8'h00}; endproperty
   a_c_pair: assert property (p_c_pair) else $error("timer c high byte not latched");
   property p_byte; byte_ff && wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
   a_byte: assert property (p_byte) else $error("byte register wider than a byte");
endmodule // tssc_asserts
bind tssc_timer_ctl tssc_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .measure_i(measure_i), .capture_i(capture_i),
   .timer_b_out_o(timer_b_out_o), .irq_o(irq_o));

// file: sim/testbench.sv
// Purpose: Self-checking bench for the timer start/stop block.
// Assumes: Register reads return the value at the edge the request is taken.
// Notes:   Source-tick phase is unknown here, so run readback is polled.
`timescale 1ns/1ps
module testbench;
   import tssc_pkg::*;
   logic             clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, measure_i, timer_b_out_o, irq_o;
   logic [ADR_W-1:0] wb_adr_i, ad;
   logic [3:0]       wb_sel_i;
   logic [DAT_W-1:0] wb_dat_i, wb_dat_o, q0, q1, q2;
   logic [1:0]       capture_i;
   logic [31:0]      seed = 32'h000099c1;
   logic [7:0]       mdl [2];
   int               n_errors = 0;
   int               checked = 0;
   tssc_timer_ctl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .measure_i(measure_i), .capture_i(capture_i), .timer_b_out_o(timer_b_out_o),
      .irq_o(irq_o));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Ack is taken at the rising edge that samples it high; the request stands until then.
   task automatic wb(input logic [ADR_W-1:0] a, input logic w, input logic [3:0] s, input logic [DAT_W-1:0] d,
                     output logic [DAT_W-1:0] q);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) n_errors++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
      logic [DAT_W-1:0] q;
      wb(a, 1'b1, 4'hf, d, q);
   endtask
   task automatic rd(input logic [ADR_W-1:0] a, output logic [DAT_W-1:0] q);
      wb(a, 1'b0, 4'hf, 32'h0, q);
   endtask
   // Only the run bit is read while waiting, since other registers are off limits then.
   task automatic poll(input logic [ADR_W-1:0] a, input logic v);
      logic [DAT_W-1:0] q;
      int               k;
      k = 0;
      do begin
         rd(a, q);
         k++;
      end while (q[0] !== v && k < 6);
      cmp({31'h0, q[0]}, {31'h0, v});
   endtask
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      repeat (6000) @(posedge clk_i);
      n_errors++;
      summarize();
   end
   initial begin
      rst_n_i = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, measure_i} = 4'h0;
      wb_adr_i = '0;
      wb_sel_i = 4'h0;
      wb_dat_i = '0;
      capture_i = 2'h0;
      mdl[0] = 8'h02;
      mdl[1] = 8'h30;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      rd(OFS_A_MODE, q0);
      cmp(q0, 32'h0);
      rd(OFS_B_MODE, q0);
      cmp(q0, 32'h0);
      wr(OFS_A_PRESC, 32'h2);
      wr(OFS_A_COUNT, 32'h30);
      repeat (20) @(posedge clk_i);
      rd(OFS_A_COUNT, q0);
      cmp(q0, 32'h30);
      for (int i = 0; i < 4; i++) begin
         q1 = rnd();
         q2 = rnd();
         ad = i[0] ? OFS_A_COUNT : OFS_A_PRESC;
         wb(ad, 1'b1, q2[3:0], q1, q0);
         if (q2[0]) mdl[i[0]] = q1[7:0];
         rd(ad, q0);
         cmp(q0, {24'h0, mdl[i[0]]});
      end
      wr(6'h3c, 32'hff);
      rd(6'h3c, q0);
      cmp(q0, 32'h0);
      wr(OFS_A_PRESC, 32'h2);
      wr(OFS_A_COUNT, 32'h30);
      wr(OFS_SRC_SEL, 32'h3);
      wr(OFS_A_MODE, 32'h1);
      poll(OFS_A_MODE, 1'b1);
      rd(OFS_A_COUNT, q0);
      repeat (100) @(posedge clk_i);
      rd(OFS_A_COUNT, q1);
      cmp({31'h0, q1 < q0}, 32'h1);
      wr(OFS_A_MODE, 32'h0);
      poll(OFS_A_MODE, 1'b0);
      rd(OFS_A_COUNT, q0);
      repeat (50) @(posedge clk_i);
      rd(OFS_A_COUNT, q1);
      cmp(q1, q0);
      wr(OFS_SRC_SEL, 32'h0);
      wr(OFS_A_PRESC, 32'h1);
      wr(OFS_A_COUNT, 32'h3);
      wr(OFS_A_MODE, 32'h6);
      rd(OFS_A_MODE, q0);
      cmp(q0, 32'h6);
      wr(OFS_A_MODE, 32'h7);
      poll(OFS_A_MODE, 1'b1);
      measure_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      measure_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      rd(OFS_A_MODE, q0);
      cmp(q0, 32'h37);
      wr(OFS_A_MODE, 32'h27);
      rd(OFS_A_MODE, q0);
      cmp(q0, 32'h27);
      wr(OFS_A_MODE, 32'h17);
      rd(OFS_A_MODE, q0);
      cmp(q0 & 32'h1f, 32'h7);
      wr(OFS_A_MODE, 32'h36);
      poll(OFS_A_MODE, 1'b0);
      wr(OFS_IRQ_MASK, 32'h1);
      cmp({31'h0, irq_o}, 32'h1);
      wr(OFS_IRQ_MASK, 32'h6);
      cmp({31'h0, irq_o}, 32'h0);
      wr(OFS_IRQ_MASK, 32'h1);
      wr(OFS_IRQ_STAT, 32'h1);
      rd(OFS_IRQ_STAT, q0);
      cmp(q0, 32'h0);
      cmp({31'h0, irq_o}, 32'h0);
      wr(OFS_SRC_SEL, 32'hc);
      wr(OFS_B_PRESC, 32'h1);
      wr(OFS_B_PRIMARY, 32'h20);
      wr(OFS_B_MODE, 32'h4);
      // While stopped, a one-shot stop write is the only way the counter gets its start value.
      wr(OFS_B_MODE, 32'h4);
      rd(OFS_B_COUNT, q0);
      cmp(q0, 32'h20);
      wr(OFS_B_MODE, 32'hd);
      poll(OFS_B_MODE, 1'b1);
      repeat (40) @(posedge clk_i);
      rd(OFS_B_COUNT, q0);
      cmp({31'h0, q0 < 32'h20}, 32'h1);
      cmp({31'h0, timer_b_out_o}, 32'h1);
      wr(OFS_B_MODE, 32'hc);
      poll(OFS_B_MODE, 1'b0);
      cmp({31'h0, timer_b_out_o}, 32'h0);
      rd(OFS_B_COUNT, q0);
      cmp(q0, 32'h20);
      wr(OFS_C_CTRL, 32'h1);
      repeat (300) @(posedge clk_i);
      rd(OFS_C_COUNT, q0);
      wb(OFS_C_COUNT, 1'b0, 4'he, 32'h0, q1);
      cmp(q1, {16'h0, q0[15:8], 8'h00});
      rd(OFS_C_COUNT, q2);
      cmp(q2, q0 + 32'h6);
      // The rise is seen one edge later, three counts after the last read was taken.
      capture_i <= 2'h3;
      @(posedge clk_i);
      rd(OFS_C_CAP0, q0);
      cmp(q0, q2 + 32'h3);
      rd(OFS_C_CAP1, q1);
      cmp(q1, q2 + 32'h3);
      summarize();
   end
endmodule // testbench
